/* File: logic/flash_seq_pkg.sv */
// Constants for the flash command sequencer: map, resets, codes, timing.
// Assumes a 250 MHz core clock and a word-wide AHB-Lite register bus.
`default_nettype none
package flash_seq_pkg;
	// Timing, each time in its own unit, then the cycle count
	localparam int unsigned CLK_MHZ             = 250;
	localparam int unsigned PROGRAM_TIME_US     = 50;
	localparam int unsigned ERASE_WRITE_TIME_MS = 20;
	localparam int unsigned MASS_ERASE_TIME_MS  = 2480; // 2.48 s
	localparam int unsigned PROGRAM_CYC     = PROGRAM_TIME_US * CLK_MHZ;
	localparam int unsigned ERASE_WRITE_CYC =
		ERASE_WRITE_TIME_MS * 1000 * CLK_MHZ;
	localparam int unsigned MASS_ERASE_CYC  =
		MASS_ERASE_TIME_MS * 1000 * CLK_MHZ;
	localparam int unsigned PAGE_ERASE_CYC  = ERASE_WRITE_CYC;
	localparam int unsigned SIGNATURE_CYC   = 32778;
	localparam int unsigned SHORT_OP_CYC    = 2;
	// Array geometry in 16-bit words
	localparam int unsigned FLASH_WORDS  = 32768;
	localparam int unsigned PAGE_WORDS   = 256;
	localparam int unsigned KERNEL_WORDS = 1024; // 2 kB kept
	// Register byte addresses
	localparam logic [31:0] ADDR_STATUS     = 32'hffff0e80;
	localparam logic [31:0] ADDR_MODE       = 32'hffff0e84;
	localparam logic [31:0] ADDR_CMD        = 32'hffff0e88;
	localparam logic [31:0] ADDR_DATA       = 32'hffff0e8c;
	localparam logic [31:0] ADDR_ADDR       = 32'hffff0e90;
	localparam logic [31:0] ADDR_SIGN       = 32'hffff0e98;
	localparam logic [31:0] ADDR_PROT       = 32'hffff0e9c;
	localparam logic [31:0] ADDR_IRQ_STATUS = 32'hffff0eb0;
	localparam logic [31:0] ADDR_IRQ_MASK   = 32'hffff0eb4;
	// Values after reset
	localparam logic [7:0]  MODE_RST     = 8'h80;
	localparam logic [23:0] SIGN_RST     = 24'hffffff;
	localparam logic [1:0]  IRQ_MASK_RST = 2'h3;
	// Field positions
	localparam int unsigned MODE_WEN    = 3;
	localparam int unsigned MODE_IEN    = 4;
	localparam int unsigned WP_TOP_BIT  = 30;
	localparam logic [6:0]  WP_TOP_PAGE = 7'h78;
	// Command codes
	localparam logic [7:0] CMD_NULL       = 8'h00;
	localparam logic [7:0] CMD_READ       = 8'h01;
	localparam logic [7:0] CMD_PROG       = 8'h02;
	localparam logic [7:0] CMD_ERASE_PROG = 8'h03;
	localparam logic [7:0] CMD_VERIFY     = 8'h04;
	localparam logic [7:0] CMD_PAGE_ERASE = 8'h05;
	localparam logic [7:0] CMD_MASS       = 8'h06;
	localparam logic [7:0] CMD_READBACK   = 8'h07;
	localparam logic [7:0] CMD_SIGN       = 8'h0b;
	localparam logic [7:0] CMD_PROTECT    = 8'h0c;
	localparam logic [7:0] CMD_PING       = 8'h0f;
	// Keys and array constants
	localparam logic [15:0] MASS_KEY      = 16'hffc3;
	localparam logic [2:0]  PROT_KEY_MODE = 3'h5;
	localparam logic [15:0] ERASED_WORD   = 16'hffff;
	localparam logic [23:0] SIGN_SEED     = 24'hffffff;
	typedef enum logic [2:0] {
		OP_NONE, OP_READ, OP_PROG, OP_PAGE_ERASE,
		OP_ERASE_PROG, OP_MASS, OP_SIGN
	} flash_op_t;
endpackage : flash_seq_pkg
`default_nettype wire

/* File: logic/flash_op_if.sv */
// Operation channel between the sequencer and the flash array.
// Assumes both ends share hclk; start is a one-cycle request.
`timescale 1ns/1ps
`default_nettype none
interface flash_op_if #(parameter int IDX_W = 15);
	import flash_seq_pkg::*;
	logic             start;
	flash_op_t        op;
	logic [IDX_W-1:0] index;
	logic [15:0]      wdata;
	logic [15:0]      rdata;
	logic [23:0]      sig;
	logic             done;
	modport seq (output start, op, index, wdata, input rdata, sig, done);
	modport mem (input start, op, index, wdata, output rdata, sig, done);
endinterface : flash_op_if
`default_nettype wire

/* File: logic/op_timer.sv */
// Down counter that marks the end of an operation's duration.
// Assumes start only while idle; done pulses once, cycles edges later.
`timescale 1ns/1ps
`default_nettype none
module op_timer
	import flash_seq_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        start,
	input  wire logic [31:0] cycles,
	output logic             done
);
	typedef struct packed {
		logic [31:0] count;
		logic        run;
		logic        done;
	} timer_state_t;
	timer_state_t r;
	timer_state_t next_r;

	// Load, count down, pulse on the last cycle
	always_comb
	begin
		next_r = r;
		next_r.done = 1'b0;
		if (start)
		begin
			next_r.count = (cycles == 32'h0) ? 32'h1 : cycles;
			next_r.run   = 1'b1;
		end
		else if (r.run)
		begin
			next_r.count = r.count - 32'h1;
			if (r.count == 32'h1)
			begin
				next_r.run  = 1'b0;
				next_r.done = 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			r <= '0;
		else
			r <= next_r;

	assign done = r.done;
endmodule : op_timer
`default_nettype wire

/* File: logic/flash_array.sv */
// Flash word store with single-word and walking page/mass/sign ops.
// Assumes one request at a time; contents are not reset.
`timescale 1ns/1ps
`default_nettype none
module flash_array
	import flash_seq_pkg::*;
#(
	parameter int unsigned WORDS  = FLASH_WORDS,
	parameter int unsigned PAGE   = PAGE_WORDS,
	parameter int unsigned KERNEL = KERNEL_WORDS
)
(
	input  wire logic hclk,
	input  wire logic hresetn,
	flash_op_if.mem   port
);
	localparam int unsigned IDX_W = $clog2(WORDS);
	typedef struct packed {
		logic             busy;
		flash_op_t        op;
		logic [IDX_W-1:0] ptr;
		logic [IDX_W-1:0] last;
		logic [IDX_W-1:0] target;
		logic [15:0]      wdata;
		logic [15:0]      rdata;
		logic [23:0]      sig;
		logic             done;
	} array_state_t;
	array_state_t     r;
	array_state_t     next_r;
	logic [15:0]      store [WORDS];
	logic             we;
	logic [IDX_W-1:0] wa;
	logic [15:0]      wd;

	// One word per cycle while walking; erase-program ends in a program
	always_comb
	begin
		next_r = r;
		next_r.done = 1'b0;
		we = 1'b0;
		wa = r.ptr;
		wd = ERASED_WORD;
		if (!r.busy && port.start)
		begin
			next_r.op     = port.op;
			next_r.target = port.index;
			next_r.wdata  = port.wdata;
			next_r.ptr    = port.index & ~IDX_W'(PAGE - 1);
			next_r.last   = port.index | IDX_W'(PAGE - 1);
			next_r.busy   = 1'b1;
			unique case (port.op)
				OP_READ:
				begin
					next_r.rdata = store[port.index];
					next_r.busy  = 1'b0;
					next_r.done  = 1'b1;
				end
				OP_PROG:
				begin
					next_r.ptr = port.index;
				end
				OP_PAGE_ERASE, OP_ERASE_PROG: ;
				OP_MASS:
				begin
					next_r.ptr  = IDX_W'(KERNEL);
					next_r.last = IDX_W'(WORDS - 1);
				end
				OP_SIGN:
				begin
					next_r.ptr  = '0;
					next_r.last = IDX_W'(WORDS - 1);
					next_r.sig  = SIGN_SEED;
				end
				default:
				begin
					next_r.busy = 1'b0;
					next_r.done = 1'b1;
				end
			endcase
		end
		else if (r.busy)
		begin
			next_r.ptr = r.ptr + 1'b1;
			if (r.op == OP_SIGN)
				next_r.sig = {r.sig[22:0], r.sig[23]} ^ {8'h00, store[r.ptr]};
			else
			begin
				we = 1'b1;
				wd = (r.op == OP_PROG) ? r.wdata : ERASED_WORD;
			end
			if (r.op == OP_PROG || r.ptr == r.last)
			begin
				next_r.busy = 1'b0;
				next_r.done = 1'b1;
			end
			// Page cleared: now place the data word
			if (r.op == OP_ERASE_PROG && r.ptr == r.last)
			begin
				next_r.op   = OP_PROG;
				next_r.ptr  = r.target;
				next_r.busy = 1'b1;
				next_r.done = 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			r <= '0;
		else
			r <= next_r;

	// Store write port; no reset, like the real cell array
	always_ff @(posedge hclk)
		if (we)
			store[wa] <= wd;

	assign port.rdata = r.rdata;
	assign port.sig   = r.sig;
	assign port.done  = r.done;
endmodule : flash_array
`default_nettype wire

/* File: logic/flash_command_sequencer.sv */
// Flash command sequencer with its AHB-Lite register slave and interrupt.
// Assumes single word transfers; hreadyout is the bus hready.
// Operation
// RULE_01: Code 0x01 loads the data register with the addressed 16-bit word.
// RULE_02: Program stores the data register at the address, about 50 us.
// RULE_03: Code 0x03 erases the page, then programs the word, about 20 ms.
// RULE_04: Code 0x04 compares word with data register, mismatch sets bit 1.
// RULE_05: Code 0x05 erases only the page holding the address.
// RULE_06: Code 0x06 erases all but the kernel, about 2.48 s, after unlock.
// RULE_07: Code 0x0B makes a 24-bit signature of 64 kB in 32,778 cycles.
// RULE_08: Code 0x0C saves protection once; only mass erase or key removes.
// RULE_09: Code 0x0F does nothing to flash but raises the interrupt.
// RULE_10: After codes 0x00 to 0x06 execute, command register reads 0x07.
// RULE_11: Status bit 2 is high while a command runs, low when idle.
// RULE_12: Status bits 0, 1 and 3 set on finish, fail; clear on read.
// RULE_13: Mode bit 4 enables completion interrupt and status bit 3.
// RULE_14: With mode bit 3 clear, erase and program commands are refused.
// RULE_15: Code 0x00 stays idle; reserved codes start nothing.
`timescale 1ns/1ps
`default_nettype none
module flash_command_sequencer
	import flash_seq_pkg::*;
#(
	parameter int unsigned PROG_CYCLES   = PROGRAM_CYC,
	parameter int unsigned ERPROG_CYCLES = ERASE_WRITE_CYC,
	parameter int unsigned PERASE_CYCLES = PAGE_ERASE_CYC,
	parameter int unsigned MASS_CYCLES   = MASS_ERASE_CYC,
	parameter int unsigned SIGN_CYCLES   = SIGNATURE_CYC,
	parameter int unsigned WORDS         = FLASH_WORDS,
	parameter int unsigned PAGE          = PAGE_WORDS,
	parameter int unsigned KERNEL        = KERNEL_WORDS
)
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             irq
);
	localparam int unsigned IDX_W = $clog2(WORDS);
	localparam int unsigned PG_SH = $clog2(PAGE);

	typedef enum logic {PH_IDLE, PH_RUN} phase_t;
	typedef struct packed {
		logic        pend;
		logic        pend_wr;
		logic [31:0] pend_addr;
		logic [31:0] rdata;
		logic        ready;
		logic        irq;
		logic [7:0]  cmd;
		logic [7:0]  mode;
		logic [15:0] data;
		logic [15:0] addr;
		logic [23:0] sign;
		logic [31:0] prot;
		logic [31:0] saved_prot;
		logic        locked;
		logic        unlocked;
		logic        st_done;
		logic        st_fail;
		logic        st_irq;
		logic [1:0]  irq_status;
		logic [1:0]  irq_mask;
		phase_t      phase;
		logic [7:0]  code;
		logic        t_seen;
		logic        a_seen;
	} seq_state_t;

	seq_state_t  r;
	seq_state_t  next_r;
	logic        tmr_start;
	logic [31:0] tmr_cycles;
	logic        tmr_done;
	logic        op_start;
	logic        set_done;
	logic        set_fail;
	logic        clr_read;
	logic [1:0]  irq_clr;
	logic        t_now;
	logic        a_now;
	logic        refuse;
	logic [31:0] eff_prot;
	logic [6:0]  page;
	logic [7:0]  wcode;

	flash_op_if #(.IDX_W(IDX_W)) fop ();

	// Array operation behind each command code
	function automatic flash_op_t op_of(input logic [7:0] c);
		unique case (c)
			CMD_READ, CMD_VERIFY: op_of = OP_READ;
			CMD_PROG:             op_of = OP_PROG;
			CMD_ERASE_PROG:       op_of = OP_ERASE_PROG;
			CMD_PAGE_ERASE:       op_of = OP_PAGE_ERASE;
			CMD_MASS:             op_of = OP_MASS;
			CMD_SIGN:             op_of = OP_SIGN;
			default:              op_of = OP_NONE;
		endcase
	endfunction : op_of

	// Duration of each command in clock cycles
	function automatic logic [31:0] cycles_of(input logic [7:0] c);
		unique case (c)
			CMD_PROG:       cycles_of = 32'(PROG_CYCLES); // RULE_02
			CMD_ERASE_PROG: cycles_of = 32'(ERPROG_CYCLES); // RULE_03
			CMD_PAGE_ERASE: cycles_of = 32'(PERASE_CYCLES); // RULE_05
			CMD_MASS:       cycles_of = 32'(MASS_CYCLES); // RULE_06
			CMD_SIGN:       cycles_of = 32'(SIGN_CYCLES); // RULE_07
			default:        cycles_of = 32'(SHORT_OP_CYC);
		endcase
	endfunction : cycles_of

	// Page group bit; the top eight pages share one bit
	function automatic logic wp_allows(input logic [31:0] p,
		input logic [6:0] pg);
		wp_allows = (pg >= WP_TOP_PAGE) ? p[WP_TOP_BIT] : p[pg[6:2]];
	endfunction : wp_allows

	// Saved protection only counts once the protect command has run
	assign eff_prot = r.locked ? r.saved_prot : 32'hffffffff;
	assign page     = 7'(r.addr[IDX_W:PG_SH+1]);
	assign wcode    = hwdata[7:0];

	// Reasons to finish a command at once with the fail bit
	assign refuse =
		!(wcode inside {[CMD_NULL:CMD_MASS], CMD_SIGN, CMD_PROTECT,
			CMD_PING}) || // RULE_15
		((wcode inside {CMD_PROG, CMD_ERASE_PROG, CMD_PAGE_ERASE,
			CMD_MASS, CMD_PROTECT}) && !r.mode[MODE_WEN]) || // RULE_14
		((wcode inside {CMD_PROG, CMD_ERASE_PROG, CMD_PAGE_ERASE}) &&
			!wp_allows(eff_prot, page)) ||
		(wcode == CMD_MASS && !r.unlocked) || // RULE_06
		(wcode == CMD_PROTECT && r.locked); // RULE_08

	// Bus slave, command launch, completion and status
	always_comb
	begin
		next_r = r;
		op_start = 1'b0;
		tmr_start = 1'b0;
		tmr_cycles = 32'h0;
		set_done = 1'b0;
		set_fail = 1'b0;
		clr_read = 1'b0;
		irq_clr = 2'h0;
		t_now = 1'b0;
		a_now = 1'b0;
		if (r.pend)
		begin
			next_r.pend  = 1'b0;
			next_r.ready = 1'b1;
			if (r.pend_wr)
			begin
				unique case (r.pend_addr)
					ADDR_MODE: next_r.mode = hwdata[7:0];
					ADDR_DATA: next_r.data = hwdata[15:0];
					ADDR_ADDR:
					begin
						next_r.addr = hwdata[15:0];
						next_r.unlocked = (hwdata[15:0] == MASS_KEY);
					end
					ADDR_PROT:
					begin
						next_r.prot = hwdata;
						if (r.mode[7:5] == PROT_KEY_MODE)
							next_r.locked = 1'b0; // RULE_08
					end
					ADDR_IRQ_STATUS: irq_clr = hwdata[1:0];
					ADDR_IRQ_MASK:   next_r.irq_mask = hwdata[1:0];
					ADDR_CMD:
					begin
						// Writes while busy are dropped, operands stay put
						if (r.phase == PH_IDLE)
						begin
							next_r.cmd = wcode;
							next_r.unlocked = 1'b0;
							if (wcode == CMD_NULL)
								next_r.cmd = CMD_READBACK; // RULE_15 RULE_10
							else if (refuse)
							begin
								set_done = 1'b1;
								set_fail = 1'b1;
							end
							else
							begin
								next_r.phase  = PH_RUN;
								next_r.code   = wcode;
								next_r.t_seen = 1'b0;
								next_r.a_seen = (op_of(wcode) == OP_NONE);
								op_start   = (op_of(wcode) != OP_NONE);
								tmr_start  = 1'b1;
								// Finish costs one more edge, so load one short
								tmr_cycles = cycles_of(wcode) - 32'h1;
							end
						end
					end
					default: ;
				endcase
			end
			else
			begin
				unique case (r.pend_addr)
					ADDR_STATUS:
					begin
						next_r.rdata = {28'h0, r.st_irq, r.phase == PH_RUN,
							r.st_fail, r.st_done}; // RULE_11
						clr_read = 1'b1; // RULE_12
					end
					ADDR_MODE:       next_r.rdata = {24'h0, r.mode};
					ADDR_CMD:        next_r.rdata = {24'h0, r.cmd};
					ADDR_DATA:       next_r.rdata = {16'h0, r.data};
					ADDR_ADDR:       next_r.rdata = {16'h0, r.addr};
					ADDR_SIGN:       next_r.rdata = {8'h0, r.sign};
					ADDR_PROT:       next_r.rdata = r.prot;
					ADDR_IRQ_STATUS: next_r.rdata = {30'h0, r.irq_status};
					ADDR_IRQ_MASK:   next_r.rdata = {30'h0, r.irq_mask};
					default:         next_r.rdata = 32'h0;
				endcase
			end
		end
		else if (hsel && htrans[1] && hready)
		begin
			// Address phase taken; one wait state gives registered data
			next_r.pend      = 1'b1;
			next_r.pend_wr   = hwrite;
			next_r.pend_addr = haddr;
			next_r.ready     = 1'b0;
		end

		// Finish when both the duration and the array work are over
		if (r.phase == PH_RUN)
		begin
			t_now = r.t_seen | tmr_done;
			a_now = r.a_seen | fop.done;
			next_r.t_seen = t_now;
			next_r.a_seen = a_now;
			if (t_now && a_now)
			begin
				next_r.phase = PH_IDLE; // RULE_11
				set_done = 1'b1; // RULE_09
				unique case (r.code)
					CMD_READ:    next_r.data = fop.rdata; // RULE_01
					CMD_VERIFY:  set_fail = (fop.rdata != r.data); // RULE_04
					CMD_SIGN:    next_r.sign = fop.sig; // RULE_07
					CMD_PROTECT:
					begin
						next_r.saved_prot = r.prot; // RULE_08
						next_r.locked = 1'b1;
					end
					CMD_MASS:    next_r.locked = 1'b0; // RULE_08
					default: ;
				endcase
				if (r.code <= CMD_MASS)
					next_r.cmd = CMD_READBACK; // RULE_10
			end
		end

		// Sticky flags: a set in the clearing cycle wins
		next_r.st_done = (r.st_done & ~clr_read) | set_done; // RULE_12
		next_r.st_fail = (r.st_fail & ~clr_read) | set_fail; // RULE_12
		next_r.st_irq = (r.st_irq & ~clr_read) |
			(set_done & r.mode[MODE_IEN]); // RULE_13
		next_r.irq_status = (r.irq_status & ~irq_clr) |
			({set_fail, set_done} & {2{r.mode[MODE_IEN]}}); // RULE_13
		next_r.irq = |(next_r.irq_status & next_r.irq_mask);
	end

	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			r            <= '0;
			r.ready      <= 1'b1;
			r.mode       <= MODE_RST;
			r.sign       <= SIGN_RST;
			r.irq_mask   <= IRQ_MASK_RST;
			r.saved_prot <= 32'hffffffff;
		end
		else
			r <= next_r;

	// Operands come straight from the registers at launch
	assign fop.start = op_start;
	assign fop.op    = op_of(wcode);
	assign fop.index = r.addr[IDX_W:1];
	assign fop.wdata = r.data;

	op_timer u_timer (
		.hclk    (hclk),
		.hresetn (hresetn),
		.start   (tmr_start),
		.cycles  (tmr_cycles),
		.done    (tmr_done)
	);

	flash_array #(
		.WORDS  (WORDS),
		.PAGE   (PAGE),
		.KERNEL (KERNEL)
	) u_array (
		.hclk    (hclk),
		.hresetn (hresetn),
		.port    (fop.mem)
	);

	assign hrdata    = r.rdata;
	assign hreadyout = r.ready;
	assign hresp     = 1'b0; // Always OKAY
	assign irq       = r.irq;
endmodule : flash_command_sequencer
`default_nettype wire

/* File: sim/flash_seq_monitor.sv */
// Port checker for the flash command sequencer.
// Assumes a bind onto the top module; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module flash_seq_monitor
	import flash_seq_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        irq
);
	logic        dp;
	logic        dp_w;
	logic [31:0] dp_a;
	logic        idle_seen;
	logic        stat_clean;
	logic        cmd_zero;
	logic        ien;
	wire logic   take = hsel && htrans[1] && hready;
	wire logic   fin = dp && hready;
	wire logic   rd_fin = fin && !dp_w;
	wire logic   wr_fin = fin && dp_w;

	// Data phase tracking and shadows of what software last saw
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dp <= 1'b0;
			dp_w <= 1'b0;
			dp_a <= 32'h0;
			idle_seen <= 1'b0;
			stat_clean <= 1'b0;
			cmd_zero <= 1'b0;
			ien <= 1'b0;
		end
		else
		begin
			if (take)
			begin
				dp <= 1'b1;
				dp_w <= hwrite;
				dp_a <= haddr;
			end
			else if (fin)
				dp <= 1'b0;
			// Idle seen in a status read; any command write voids it
			if (rd_fin && dp_a == ADDR_STATUS)
			begin
				stat_clean <= !hrdata[2];
				idle_seen <= !hrdata[2];
			end
			if (wr_fin && dp_a == ADDR_CMD)
			begin
				stat_clean <= 1'b0;
				idle_seen <= 1'b0;
				cmd_zero <= idle_seen && hwdata[7:0] == CMD_NULL;
			end
			if (wr_fin && dp_a == ADDR_MODE)
				ien <= hwdata[MODE_IEN];
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_OKAY: assert property (hresp == 1'b0)
		else $error("error response seen");
	AST_WAIT: assert property (take |=> !hreadyout ##1 hreadyout)
		else $error("data phase not one wait state");
	AST_HOLD: assert property (!$stable(hrdata) |-> rd_fin)
		else $error("read data moved outside a read");
	AST_CLEAN: assert property (
		rd_fin && dp_a == ADDR_STATUS && stat_clean |-> hrdata[3:0] == 4'h0)
		else $error("status flags survived a read");
	AST_CMD7: assert property (
		rd_fin && dp_a == ADDR_CMD && cmd_zero |-> hrdata == 32'h7)
		else $error("command register not 0x07 after null");
	AST_SIGN: assert property (
		rd_fin && dp_a == ADDR_SIGN |-> hrdata[31:24] == 8'h00)
		else $error("signature wider than 24 bits");
	AST_IRQ_RISE: assert property (
		$rose(irq) |-> ien || wr_fin || $past(wr_fin))
		else $error("interrupt with enable clear");
	AST_IRQ_FALL: assert property (
		$fell(irq) |-> wr_fin)
		else $error("interrupt dropped without a clear");

	// Main scenarios reached
	cover property (wr_fin && dp_a == ADDR_CMD);
	cover property ($rose(irq));
	cover property (rd_fin && dp_a == ADDR_SIGN);
endmodule : flash_seq_monitor
`default_nettype wire

/* File: sim/flash_command_sequencer_tb.sv */
// Self-checking bench for the flash command sequencer.
// Assumes shortened timings; the bench is the only bus master.
`timescale 1ns/1ps
`default_nettype none
module flash_command_sequencer_tb;
	import flash_seq_pkg::*;
	localparam int W = 256;
	localparam int P = 2;
	localparam int K = 8;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        irq;
	wire logic   hready = hreadyout;
	int          miscompares;
	int          checks;
	int          idx;
	logic [31:0] r;
	logic [31:0] st;
	logic        busy1;
	logic [15:0] v;
	logic [7:0]  rsv [7] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0d, 8'h0e, 8'h10};
	logic [7:0]  wop [5] = '{CMD_PROG, CMD_ERASE_PROG, CMD_PAGE_ERASE,
		CMD_MASS, CMD_PROTECT};

	flash_command_sequencer #(.PROG_CYCLES(20), .ERPROG_CYCLES(40),
		.PERASE_CYCLES(30), .MASS_CYCLES(50), .SIGN_CYCLES(60),
		.WORDS(W), .PAGE(P), .KERNEL(K)) DUT (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .irq(irq));

	// Clock, 4 ns period
	initial
	begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	task automatic close_out;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	// One single word transfer; waits on hready, no fixed latency
	task automatic ahb(input logic w, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask : ahb

	// Issue a command, poll until idle, then see the flags clear
	task automatic run(input logic [7:0] c, input logic f);
		ahb(1'b1, ADDR_CMD, {24'h0, c}, r);
		ahb(1'b0, ADDR_STATUS, 32'h0, st);
		busy1 = st[2];
		while (st[2] === 1'b1)
			ahb(1'b0, ADDR_STATUS, 32'h0, st);
		chk(st[1:0], {f, 1'b1});
		ahb(1'b0, ADDR_STATUS, 32'h0, r);
		chk(r, 32'h0);
	endtask : run

	task automatic at(input int i);
		ahb(1'b1, ADDR_ADDR, i * 2, r);
	endtask : at

	task automatic sd(input logic [15:0] d);
		ahb(1'b1, ADDR_DATA, {16'h0, d}, r);
	endtask : sd

	task automatic rword(input int i, input logic [15:0] e);
		at(i);
		run(CMD_READ, 1'b0);
		ahb(1'b0, ADDR_DATA, 32'h0, r);
		chk(r, {16'h0, e});
	endtask : rword

	// Signature of an all-erased array
	function automatic logic [23:0] sig_of(input int n);
		logic [23:0] s;
		s = SIGN_SEED;
		for (int i = 0; i < n; i++)
			s = {s[22:0], s[23]} ^ {8'h00, ERASED_WORD};
		return s;
	endfunction : sig_of

	// Watchdog, about twelve times the expected run length
	initial
	begin
		#100000;
		miscompares++;
		close_out();
	end

	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		void'($urandom(56808));
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, ADDR_MODE, 32'h0, r);
		chk(r, {24'h0, MODE_RST});
		ahb(1'b0, ADDR_SIGN, 32'h0, r);
		chk(r, {8'h0, SIGN_RST});
		ahb(1'b0, ADDR_IRQ_MASK, 32'h0, r);
		chk(r, {30'h0, IRQ_MASK_RST});
		ahb(1'b0, 32'hffff0ea8, 32'h0, r);
		chk(r, 32'h0);
		$display("test reset values done");
		// Refusals with writes disabled, then reserved codes
		ahb(1'b1, ADDR_MODE, 32'h10, r);
		foreach (wop[i])
			run(wop[i], 1'b1);
		foreach (rsv[i])
			run(rsv[i], 1'b1);
		ahb(1'b1, ADDR_IRQ_STATUS, 32'h3, r);
		chk(irq, 1'b0);
		run(CMD_PING, 1'b0);
		chk(st[3], 1'b1);
		chk(irq, 1'b1);
		ahb(1'b1, ADDR_IRQ_STATUS, 32'h3, r);
		repeat (2) @(posedge hclk);
		chk(irq, 1'b0);
		ahb(1'b1, ADDR_CMD, 32'h0, r);
		ahb(1'b0, ADDR_CMD, 32'h0, r);
		chk(r, 32'h7);
		ahb(1'b0, ADDR_STATUS, 32'h0, r);
		chk(r, 32'h0);
		$display("test refusals done");
		// Mass erase needs the unlock; kernel pages erased by hand
		ahb(1'b1, ADDR_MODE, 32'h08, r);
		run(CMD_MASS, 1'b1);
		ahb(1'b1, ADDR_ADDR, {16'h0, MASS_KEY}, r);
		run(CMD_MASS, 1'b0);
		chk(busy1, 1'b1);
		chk(irq, 1'b0);
		for (int p = 0; p < K; p += P)
		begin
			at(p);
			run(CMD_PAGE_ERASE, 1'b0);
		end
		run(CMD_SIGN, 1'b0);
		ahb(1'b0, ADDR_SIGN, 32'h0, r);
		chk(r, {8'h0, sig_of(W)});
		$display("test erase and signature done");
		// Random words, one per slot so no word is programmed twice
		for (int k = 0; k < 4; k++)
		begin
			idx = K + 32 * k + int'($urandom_range(15));
			v = 16'($urandom);
			at(idx);
			sd(v);
			run(CMD_PROG, 1'b0);
			chk(busy1, 1'b1);
			run(CMD_VERIFY, 1'b0);
			sd(v ^ 16'h0001);
			run(CMD_VERIFY, 1'b1);
			rword(idx, v);
			ahb(1'b0, ADDR_CMD, 32'h0, r);
			chk(r, 32'h7);
		end
		$display("test program verify done");
		// Erase-and-program clears the neighbour; page erase is local
		at(idx + 16);
		sd(16'h1234);
		run(CMD_PROG, 1'b0);
		at(idx ^ 1);
		run(CMD_PROG, 1'b0);
		at(idx);
		sd(16'h5a3c);
		run(CMD_ERASE_PROG, 1'b0);
		rword(idx, 16'h5a3c);
		rword(idx ^ 1, ERASED_WORD);
		at(idx);
		run(CMD_PAGE_ERASE, 1'b0);
		rword(idx, ERASED_WORD);
		rword(idx + 16, 16'h1234);
		$display("test page ops done");
		// Protection is saved once and lifted by mass erase
		ahb(1'b1, ADDR_PROT, 32'hfffffffe, r);
		run(CMD_PROTECT, 1'b0);
		run(CMD_PROTECT, 1'b1);
		at(0);
		run(CMD_PAGE_ERASE, 1'b1);
		ahb(1'b1, ADDR_ADDR, {16'h0, MASS_KEY}, r);
		run(CMD_MASS, 1'b0);
		at(0);
		run(CMD_PAGE_ERASE, 1'b0);
		// Lock again, then lift it with the key instead
		run(CMD_PROTECT, 1'b0);
		run(CMD_PAGE_ERASE, 1'b1);
		ahb(1'b1, ADDR_MODE, 32'ha8, r);
		ahb(1'b1, ADDR_PROT, 32'hffffffff, r);
		ahb(1'b1, ADDR_MODE, 32'h08, r);
		run(CMD_PAGE_ERASE, 1'b0);
		$display("test protection done");
		close_out();
	end
endmodule : flash_command_sequencer_tb

bind flash_command_sequencer flash_seq_monitor mon (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
	.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .irq(irq));
`default_nettype wire
